// File: rtl/pmic_regs_pkg.sv
// Shared offsets, field positions, reset values and carrier types of the shutdown and rail bank
package pmic_regs_pkg;

  // Register offsets on the control port
  localparam logic [7:0] OFF_SHUTDOWN_CAUSE = 8'h05;  // shutdown_cause_flags
  localparam logic [7:0] OFF_RAIL_B_VOLTAGE = 8'h21;  // rail_b_voltage_ctrl
  localparam logic [7:0] OFF_RAIL_C_DECAY   = 8'h22;  // rail_c_decay_ctrl
  localparam logic [7:0] OFF_RAIL_C_VOLTAGE = 8'h23;  // rail_c_voltage_code
  localparam logic [7:0] OFF_RAIL_C_SLEEP   = 8'h24;  // rail_c_sleep_code

  // Shutdown cause bit positions
  localparam int BIT_CRIT_TEMP   = 0;  // critical_temp_cause
  localparam int BIT_POWER_FAULT = 1;  // power_fault_cause
  localparam int BIT_UNDERVOLT   = 2;  // undervoltage_cause
  localparam int BIT_COLD_OFF    = 3;  // cold_off_cause, tied low here
  localparam int NUM_CAUSES      = 3;  // Flags that hardware can set

  // Rail register field positions
  localparam int VID_MSB = 7;  // Voltage code top bit
  localparam int VID_LSB = 1;  // Voltage code bottom bit
  localparam int LOW_BIT = 0;  // Decay, sleep enable or reserved bit

  // Reset values
  localparam logic [2:0] RST_CAUSE         = 3'h0;   // No cause recorded
  localparam logic [7:0] RST_RAIL_B_VOLTAGE = 8'h50;  // Code 28h, active slew
  localparam logic [7:0] RST_RAIL_C_DECAY   = 8'h70;  // Don't-care 38h, active slew
  localparam logic [7:0] RST_RAIL_C_VOLTAGE = 8'h70;  // Code 38h
  localparam logic [7:0] RST_RAIL_C_SLEEP   = 8'h70;  // Code 38h, sleep disabled

  // Voltage step granularities in millivolts
  localparam logic [4:0] STEP_FINE_MV   = 5'h0a;  // 10 mV range
  localparam logic [4:0] STEP_COARSE_MV = 5'h19;  // 25 mV range

  // One rail's regulation controls
  typedef struct packed {
    logic [6:0] code;   // Output voltage code
    logic       decay;  // 1 = passive decay, 0 = active slew down
  } rail_ctrl_t;

  // Shutdown events from the protection logic
  typedef struct packed {
    logic undervolt;    // Supply fell below 5.4 V
    logic power_fault;  // Unmasked rail power fault
    logic crit_temp;    // Die above critical threshold
  } cause_events_t;

endpackage

// File: rtl/shutdown_cause_and_rail_vid_regs.sv
// Shutdown cause flags and second/third step-down rail voltage and decay registers
`timescale 1ns/1ps

module shutdown_cause_and_rail_vid_regs #(
  parameter bit SLEEP_PIN_SEL   = 1'b0,  // Factory choice: 0 = pin a, 1 = pin b
  parameter bit FINE_STEP_RANGE = 1'b1   // Factory choice: 1 = 10 mV, 0 = 25 mV steps
) (
  input  wire logic                        sys_clk,              // 10 MHz logic clock
  input  wire logic                        rst,                  // Async reset, active high
  input  wire logic [7:0]                  reg_addr,             // Register offset
  input  wire logic [7:0]                  reg_wdata,            // Write data
  input  wire logic                        reg_wr,               // Write strobe, one cycle
  input  wire logic                        reg_rd,               // Read strobe, one cycle
  output logic [7:0]                       reg_rdata,            // Read data, held
  output logic                             reg_rvalid,           // Read data valid pulse
  input  wire pmic_regs_pkg::cause_events_t shutdown_events,     // Async shutdown levels
  input  wire logic                        sleep_control_pin_a,  // Async sleep pin a
  input  wire logic                        sleep_control_pin_b,  // Async sleep pin b
  output pmic_regs_pkg::rail_ctrl_t        rail_b,               // Second rail controls
  output pmic_regs_pkg::rail_ctrl_t        rail_c,               // Third rail controls
  output logic                             rail_c_sleep_active,  // Third rail in sleep
  output logic [4:0]                       vid_step_mv,          // Code step size in mV
  output logic                             shutdown_indicator_set, // Pulse to interrupt reg
  output logic                             causes_pending        // Any cause flag still set
);

  // Address match, used by both the read and the write decode
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
    addr_is = (addr == off);
  endfunction

  // Storage
  logic [2:0] cause;            // Hardware-set shutdown cause flags
  logic [7:0] rail_b_reg;       // rail_b_voltage_ctrl
  logic [7:0] rail_c_decay_reg; // rail_c_decay_ctrl
  logic [7:0] rail_c_vid_reg;   // rail_c_voltage_code
  logic [7:0] rail_c_sleep_reg; // rail_c_sleep_code

  // Synchronisers for the analog-side events and sleep pins
  logic [2:0] event_meta;       // First stage, read by second stage only
  logic [2:0] event_sync;       // Safe event levels
  logic [2:0] event_prev;       // For rising edge detect
  logic [1:0] pin_meta;         // First stage of the sleep pins
  logic [1:0] pin_sync;         // Safe sleep pin levels
  logic       sleep_prev;       // Selected pin, one cycle back

  // Write decode
  wire wr_cause    = reg_wr & addr_is(reg_addr, pmic_regs_pkg::OFF_SHUTDOWN_CAUSE);
  wire wr_rail_b   = reg_wr & addr_is(reg_addr, pmic_regs_pkg::OFF_RAIL_B_VOLTAGE);
  wire wr_c_decay  = reg_wr & addr_is(reg_addr, pmic_regs_pkg::OFF_RAIL_C_DECAY);
  wire wr_c_vid    = reg_wr & addr_is(reg_addr, pmic_regs_pkg::OFF_RAIL_C_VOLTAGE);
  wire wr_c_sleep  = reg_wr & addr_is(reg_addr, pmic_regs_pkg::OFF_RAIL_C_SLEEP);

  // Event edges: a level held high records its cause only once
  wire [2:0] cause_rise = event_sync & ~event_prev;

  // Host clear mask, bit 3 ignored since cold-off is not stored
  wire [2:0] cause_clear = wr_cause ? reg_wdata[2:0] : 3'h0;

  // Set beats clear so an event in the clearing cycle is kept
  wire [2:0] next_cause = (cause & ~cause_clear) | cause_rise;

  // Sleep pin selection and entry detect
  wire sleep_pin   = SLEEP_PIN_SEL ? pin_sync[1] : pin_sync[0];
  wire sleep_en    = rail_c_sleep_reg[pmic_regs_pkg::LOW_BIT];
  wire sleep_entry = sleep_en & sleep_pin & ~sleep_prev;

  // Rail C code: sleep entry overrides a host write in the same cycle
  wire [7:0] next_rail_c_vid =
    sleep_entry ? {rail_c_sleep_reg[pmic_regs_pkg::VID_MSB:pmic_regs_pkg::VID_LSB],
                   rail_c_vid_reg[pmic_regs_pkg::LOW_BIT]}
                : (wr_c_vid ? reg_wdata : rail_c_vid_reg);

  // Read mux; unmapped offsets answer zero
  wire [7:0] cause_view = {4'h0, 1'b0, cause};
  wire [7:0] next_rdata =
    addr_is(reg_addr, pmic_regs_pkg::OFF_SHUTDOWN_CAUSE) ? cause_view       :
    addr_is(reg_addr, pmic_regs_pkg::OFF_RAIL_B_VOLTAGE) ? rail_b_reg       :
    addr_is(reg_addr, pmic_regs_pkg::OFF_RAIL_C_DECAY)   ? rail_c_decay_reg :
    addr_is(reg_addr, pmic_regs_pkg::OFF_RAIL_C_VOLTAGE) ? rail_c_vid_reg   :
    addr_is(reg_addr, pmic_regs_pkg::OFF_RAIL_C_SLEEP)   ? rail_c_sleep_reg :
                                                           8'h00;

  // Two-flop synchronisers, then one flop for the edge detect
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      event_meta <= 3'h0;
      event_sync <= 3'h0;
      event_prev <= 3'h0;
      pin_meta   <= 2'h0;
      pin_sync   <= 2'h0;
      sleep_prev <= 1'b0;
    end
    else
    begin
      event_meta <= shutdown_events;
      event_sync <= event_meta;
      event_prev <= event_sync;
      pin_meta   <= {sleep_control_pin_b, sleep_control_pin_a};
      pin_sync   <= pin_meta;
      sleep_prev <= sleep_pin;
    end
  end

  // Shutdown cause flags and the indicator hand-off
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cause                  <= pmic_regs_pkg::RST_CAUSE;
      shutdown_indicator_set <= 1'b0;
      causes_pending         <= 1'b0;
    end
    else
    begin
      cause                  <= next_cause;
      shutdown_indicator_set <= |cause_rise;
      causes_pending         <= |next_cause;
    end
  end

  // Rail control registers; read/write storage, with the rail C code also loaded on a sleep entry
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rail_b_reg       <= pmic_regs_pkg::RST_RAIL_B_VOLTAGE;
      rail_c_decay_reg <= pmic_regs_pkg::RST_RAIL_C_DECAY;
      rail_c_vid_reg   <= pmic_regs_pkg::RST_RAIL_C_VOLTAGE;
      rail_c_sleep_reg <= pmic_regs_pkg::RST_RAIL_C_SLEEP;
    end
    else
    begin
      if (wr_rail_b)
        rail_b_reg <= reg_wdata;
      if (wr_c_decay)
        rail_c_decay_reg <= reg_wdata;
      if (wr_c_sleep)
        rail_c_sleep_reg <= reg_wdata;
      rail_c_vid_reg <= next_rail_c_vid;
    end
  end

  // Read port: data one cycle after the strobe, held until the next read
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // Sleep state and step-size outputs
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rail_c_sleep_active <= 1'b0;
      vid_step_mv         <= pmic_regs_pkg::STEP_COARSE_MV;
    end
    else
    begin
      rail_c_sleep_active <= sleep_en & sleep_pin;
      vid_step_mv         <= FINE_STEP_RANGE ? pmic_regs_pkg::STEP_FINE_MV
                                             : pmic_regs_pkg::STEP_COARSE_MV;
    end
  end

  // Rail outputs straight from the stored bits; upper decay bits stay unused
  assign rail_b.code  = rail_b_reg[pmic_regs_pkg::VID_MSB:pmic_regs_pkg::VID_LSB];
  assign rail_b.decay = rail_b_reg[pmic_regs_pkg::LOW_BIT];
  assign rail_c.code  = rail_c_vid_reg[pmic_regs_pkg::VID_MSB:pmic_regs_pkg::VID_LSB];
  assign rail_c.decay = rail_c_decay_reg[pmic_regs_pkg::LOW_BIT];

  // Checks on the logic above
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_cold_off_zero: assert property (
    reg_rd && addr_is(reg_addr, pmic_regs_pkg::OFF_SHUTDOWN_CAUSE) |=> !reg_rdata[3])
    else $error("cold-off cause read as one");

  a_cause_upper_zero: assert property (
    reg_rd && addr_is(reg_addr, pmic_regs_pkg::OFF_SHUTDOWN_CAUSE)
      |=> reg_rvalid && reg_rdata[7:4] == 4'h0)
    else $error("reserved cause bits read nonzero");

  a_undervolt_sets: assert property (
    cause_rise[pmic_regs_pkg::BIT_UNDERVOLT] |=> cause[pmic_regs_pkg::BIT_UNDERVOLT])
    else $error("undervoltage event not recorded");

  a_power_fault_sets: assert property (
    $rose(event_sync[pmic_regs_pkg::BIT_POWER_FAULT]) |=> cause[pmic_regs_pkg::BIT_POWER_FAULT])
    else $error("power fault event not recorded");

  a_crit_temp_sets: assert property (
    $rose(event_sync[pmic_regs_pkg::BIT_CRIT_TEMP]) |=> cause[pmic_regs_pkg::BIT_CRIT_TEMP])
    else $error("critical temperature event not recorded");

  a_clear_by_one: assert property (
    wr_cause && reg_wdata[pmic_regs_pkg::BIT_UNDERVOLT]
      && !cause_rise[pmic_regs_pkg::BIT_UNDERVOLT]
      |=> !cause[pmic_regs_pkg::BIT_UNDERVOLT])
    else $error("write one did not clear flag");

  a_flag_holds: assert property (
    cause[pmic_regs_pkg::BIT_CRIT_TEMP] && !(wr_cause && reg_wdata[pmic_regs_pkg::BIT_CRIT_TEMP])
      |=> cause[pmic_regs_pkg::BIT_CRIT_TEMP])
    else $error("flag lost without write one");

  a_set_wins_clear: assert property (
    wr_cause && reg_wdata[pmic_regs_pkg::BIT_POWER_FAULT]
      && cause_rise[pmic_regs_pkg::BIT_POWER_FAULT]
      |=> cause[pmic_regs_pkg::BIT_POWER_FAULT])
    else $error("event lost during clear");

  a_indicator_pulse: assert property (
    $rose(event_sync[pmic_regs_pkg::BIT_UNDERVOLT]) |=> shutdown_indicator_set && causes_pending)
    else $error("shutdown indicator not raised");

  a_sleep_copy: assert property (
    sleep_entry && !wr_c_sleep |=> rail_c.code == $past(rail_c_sleep_reg[7:1])
      ##1 ($past(wr_c_vid) || rail_c.code == $past(rail_c.code)))
    else $error("sleep code not copied");

  a_no_copy_disabled: assert property (
    !sleep_en && !wr_c_vid |=> $stable(rail_c_vid_reg))
    else $error("voltage code changed with sleep disabled");

  a_rail_b_write: assert property (
    wr_rail_b |=> rail_b.code == $past(reg_wdata[7:1]) && rail_b.decay == $past(reg_wdata[0]))
    else $error("rail b write not stored");

  a_rail_b_hold: assert property (
    !wr_rail_b |=> $stable(rail_b))
    else $error("rail b changed without a write");

  // Read answers: one cycle after the strobe, from the addressed storage
  a_rail_b_read: assert property (
    reg_rd && addr_is(reg_addr, pmic_regs_pkg::OFF_RAIL_B_VOLTAGE)
      |=> reg_rvalid && reg_rdata == $past(rail_b_reg))
    else $error("rail b read wrong");

  a_rail_c_read: assert property (
    reg_rd && addr_is(reg_addr, pmic_regs_pkg::OFF_RAIL_C_VOLTAGE)
      |=> reg_rvalid && reg_rdata == $past(rail_c_vid_reg))
    else $error("rail c code read wrong");

  a_sleep_read: assert property (
    reg_rd && addr_is(reg_addr, pmic_regs_pkg::OFF_RAIL_C_SLEEP)
      |=> reg_rvalid && reg_rdata == $past(rail_c_sleep_reg))
    else $error("sleep code read wrong");

  a_cause_read: assert property (
    reg_rd && addr_is(reg_addr, pmic_regs_pkg::OFF_SHUTDOWN_CAUSE)
      |=> reg_rvalid && reg_rdata[2:0] == $past(cause))
    else $error("cause flags read wrong");

  // Third rail storage; a sleep entry in the same cycle takes precedence
  a_rail_c_write: assert property (
    wr_c_vid && !sleep_entry |=> rail_c_vid_reg == $past(reg_wdata))
    else $error("rail c code write not stored");

  a_sleep_write: assert property (
    wr_c_sleep |=> rail_c_sleep_reg == $past(reg_wdata))
    else $error("sleep code write not stored");

  a_decay_write: assert property (
    wr_c_decay |=> rail_c_decay_reg == $past(reg_wdata))
    else $error("decay register write not stored");

  a_decay_select: assert property (
    wr_c_decay |=> rail_c.decay == $past(reg_wdata[0]))
    else $error("rail c decay select not applied");

  // Upper decay bits must never leak into the regulation code
  a_decay_no_effect: assert property (
    wr_c_decay && !wr_c_vid && !sleep_entry |=> $stable(rail_c.code))
    else $error("decay write moved rail c code");

  a_copy_keeps_low: assert property (
    sleep_entry |=> rail_c_vid_reg[0] == $past(rail_c_vid_reg[0]))
    else $error("sleep copy touched reserved bit");

  // Only the factory-selected pin may start a copy
  a_pin_no_copy: assert property (
    !sleep_pin && !wr_c_vid |=> $stable(rail_c_vid_reg))
    else $error("voltage code changed with pin idle");

  // Sleep state follows the enable and the selected pin only
  a_sleep_active_on: assert property (
    sleep_en && sleep_pin |=> rail_c_sleep_active)
    else $error("sleep state not entered");

  a_sleep_active_off: assert property (
    !sleep_en |=> !rail_c_sleep_active)
    else $error("sleep state with enable clear");

  // Step size is a factory constant once out of reset
  a_step_size: assert property (
    !$past(rst) |-> vid_step_mv == (FINE_STEP_RANGE ? pmic_regs_pkg::STEP_FINE_MV
                                                     : pmic_regs_pkg::STEP_COARSE_MV))
    else $error("step size differs from factory range");

  // Indicator hand-off and pending level
  a_indicator_cause: assert property (
    shutdown_indicator_set |-> |cause)
    else $error("indicator pulse without a cause");

  a_indicator_quiet: assert property (
    !(|cause_rise) |=> !shutdown_indicator_set)
    else $error("indicator pulse without an event");

  a_pending_level: assert property (
    causes_pending == (|cause))
    else $error("pending level disagrees with flags");

  // A host write can only clear flags, never set one
  a_host_never_sets: assert property (
    wr_cause && !(|cause_rise) |=> (cause & ~$past(cause)) == 3'h0)
    else $error("host write set a cause flag");

endmodule

// File: verif/shutdown_cause_and_rail_vid_regs_tb.sv
// Register, shutdown cause and sleep copy tests for the rail control bank
`timescale 1ns/1ps

module shutdown_cause_and_rail_vid_regs_tb;
  logic                         sys_clk = 1'b0;  // 10 MHz clock
  logic                         rst = 1'b1;      // Held at start
  logic [7:0]                   reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic                         reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
  pmic_regs_pkg::cause_events_t events = 3'h0;   // Protection levels
  logic                         pin_a = 1'b0, pin_b = 1'b0, clear_req = 1'b0;
  pmic_regs_pkg::rail_ctrl_t    rail_b, rail_c;
  logic                         sleep_active, ind_set, pending, indicator;
  logic [4:0]                   step_mv;
  int                           mismatches = 0;  // Failed compares
  int                           checked = 0;     // All compares
  logic [7:0] offs [5] = '{8'h05, 8'h21, 8'h22, 8'h23, 8'h24};
  logic [7:0] rsts [5] = '{8'h00, 8'h50, 8'h70, 8'h70, 8'h70};

  // Half period of 50 ns
  always #50 sys_clk = ~sys_clk;

  shutdown_cause_and_rail_vid_regs u_shutdown_cause_and_rail_vid_regs (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .shutdown_events(events), .sleep_control_pin_a(pin_a),
    .sleep_control_pin_b(pin_b), .rail_b(rail_b), .rail_c(rail_c),
    .rail_c_sleep_active(sleep_active), .vid_step_mv(step_mv),
    .shutdown_indicator_set(ind_set), .causes_pending(pending));

  shutdown_irq_model u_shutdown_irq_model (
    .sys_clk(sys_clk), .rst(rst), .indicator_set(ind_set),
    .causes_pending(pending), .clear_req(clear_req), .indicator(indicator));

  // One compare, counted; case inequality so unknowns fail
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe, launched on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  // Read strobe; data and valid are settled by the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("rdata", exp, reg_rdata);
  endtask

  // Host write 1 to the indicator in the interrupt register model
  task automatic irq_clear();
    @(negedge sys_clk);
    clear_req = 1'b1;
    @(negedge sys_clk);
    clear_req = 1'b0;
  endtask

  // Single place where the run ends
  task automatic complete_run();
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the fewer than 200 cycles the tests need
  initial
  begin
    #1000000;
    mismatches++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 5; i++)
      rd(offs[i], rsts[i]);
    chk("step", 8'h0a, {3'h0, step_mv});
    // Host ones cannot set cause bits; rail registers store everything
    for (int i = 0; i < 5; i++)
      wr(offs[i], (i == 0) ? 8'hff : 8'ha5);
    for (int i = 0; i < 5; i++)
      rd(offs[i], (i == 0) ? 8'h00 : 8'ha5);
    chk("rail_b", 8'ha5, rail_b);
    chk("rail_c", 8'ha5, rail_c);
    // Upper decay bits only stored; bit 0 alone reaches the rail
    wr(8'h22, 8'hfe);
    chk("rail_c decay", 8'ha4, rail_c);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    // Each cause: record, hold against zero, refuse early indicator clear
    for (int i = 0; i < 3; i++)
    begin
      @(negedge sys_clk);
      events = 3'(1 << i);
      repeat (5) @(negedge sys_clk);
      chk("indicator", 8'h01, {7'h00, indicator});
      chk("pending", 8'h01, {7'h00, pending});
      rd(8'h05, 8'(1 << i));
      wr(8'h05, 8'h00);
      rd(8'h05, 8'(1 << i));
      irq_clear();
      chk("early clear", 8'h01, {7'h00, indicator});
      wr(8'h05, 8'(1 << i));
      rd(8'h05, 8'h00);
      chk("pending", 8'h00, {7'h00, pending});
      irq_clear();
      chk("late clear", 8'h00, {7'h00, indicator});
      events = 3'h0;
    end
    // Power fault rising on the very edge of a clear write must survive;
    // one idle cycle first so the level really rises, then the third
    // edge after the rise is the edge that takes the write
    @(negedge sys_clk);
    events = 3'h2;
    @(negedge sys_clk);
    wr(8'h05, 8'h02);
    rd(8'h05, 8'h02);
    events = 3'h0;
    wr(8'h05, 8'h02);
    rd(8'h05, 8'h00);
    irq_clear();
    chk("final clear", 8'h00, {7'h00, indicator});
    // Sleep entry copies the sleep code, bit 0 of the code register kept
    wr(8'h23, 8'h4c);
    wr(8'h24, 8'h23);
    // The pin that the factory did not choose must not start a copy
    pin_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(8'h23, 8'h4c);
    chk("pin b ignored", 8'h00, {7'h00, sleep_active});
    pin_a = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(8'h23, 8'h22);
    chk("sleep code", 8'h11, {1'b0, rail_c.code});
    chk("sleep on", 8'h01, {7'h00, sleep_active});
    // Disabled sleep: pin rise leaves the code alone
    pin_a = 1'b0;
    wr(8'h24, 8'h22);
    wr(8'h23, 8'h4c);
    pin_a = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(8'h23, 8'h4c);
    chk("sleep off", 8'h00, {7'h00, sleep_active});
    complete_run();
  end
endmodule

// File: verif/shutdown_irq_model.sv
// Interrupt register shutdown indicator model facing the cause-flag handshake
`timescale 1ns/1ps

module shutdown_irq_model (
  input  wire logic sys_clk,         // Logic clock
  input  wire logic rst,             // Async reset, active high
  input  wire logic indicator_set,   // Set pulse from the cause flags
  input  wire logic causes_pending,  // Cause flags not yet cleared
  input  wire logic clear_req,       // Host writes 1 to the indicator
  output logic      indicator        // Shutdown indicator bit
);
  // Set beats clear; a clear while causes are pending is refused, so the
  // host cannot lose a shutdown report by clearing in the wrong order
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      indicator <= 1'b0;
    end
    else if (indicator_set)
    begin
      indicator <= 1'b1;
    end
    else if (clear_req && !causes_pending)
    begin
      indicator <= 1'b0;
    end
  end
endmodule
